//--- src/acq_pkg.sv
// Purpose: shared constants and types of the digital input acquisition timing engine
// Assumes: 200 MHz clock, 32-bit APB register bus
// Notes:   offsets are byte addresses, one aligned word per register
package acq_pkg;
    localparam int LINES = 8;                      // digital lines per sample
    localparam int AW    = 8;                      // sample memory address bits
    localparam logic [AW:0] DEPTH = 9'h100;        // sample memory words
    // register offsets
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_DIV   = 12'h004;
    localparam logic [11:0] OFS_COUNT = 12'h008;
    localparam logic [11:0] OFS_PRE   = 12'h00C;
    localparam logic [11:0] OFS_DELAY = 12'h010;
    localparam logic [11:0] OFS_FILT  = 12'h014;
    localparam logic [11:0] OFS_STAT  = 12'h018;
    localparam logic [11:0] OFS_DATA  = 12'h01C;
    localparam logic [11:0] OFS_LEVEL = 12'h020;
    localparam logic [11:0] OFS_RISE  = 12'h024;
    localparam logic [11:0] OFS_FALL  = 12'h028;
    localparam logic [11:0] OFS_CMD   = 12'h02C;
    // control field positions
    localparam int B_FINITE = 0;
    localparam int B_REF_EN = 1;
    localparam int B_TRG_EN = 2;
    localparam int B_ST_FALL = 3;
    localparam int B_REF_FALL = 4;
    localparam int B_CLK_FALL = 5;
    localparam int B_HOLD_EN = 6;
    localparam int B_HOLD_LOW = 7;
    localparam int B_TB_EXT = 8;
    localparam int B_FILT_EN = 9;
    localparam int B_STB_INV = 10;
    localparam int F_ST_SRC = 12;
    localparam int F_REF_SRC = 16;
    localparam int F_HOLD_SRC = 20;
    localparam int F_CLK_SRC = 24;
    // command and status bits
    localparam int C_START = 0;
    localparam int C_STOP = 1;
    localparam int S_RUN = 0;
    localparam int S_ARMED = 1;
    localparam int S_TRIGD = 2;
    localparam int S_DONE = 3;
    localparam int S_OVF = 4;
    localparam int S_CFG = 5;
    // source codes
    localparam logic [2:0] SRC_ACMP = 3'h0;        // analog comparison event
    localparam logic [3:0] CLK_SRC_TB = 4'h8;      // divided timebase
    localparam logic [3:0] CLK_SRC_CHG = 4'h9;     // change detection event
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] DIV_RST = 16'h0004;
    localparam logic [15:0] COUNT_RST = 16'h0100;
    localparam logic [7:0] FILT_RST = 8'h01;
    // filter timing
    localparam int STEP_NS = 25;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN   = 3'b011,
        ST_DONE  = 3'b100
    } acq_state_type;
endpackage

//--- src/sample_ram.sv
// Purpose: sample memory of the acquisition engine
// Assumes: one write and one read port on the same clock
// Notes:   read data is registered, so it trails the address by one cycle
`timescale 1ns/10ps
module sample_ram #(
    parameter int W  = 8,
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];               // storage, no reset needed

    // write side
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read keeps the output a clean flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

//--- src/acq_timing_engine.sv
// Purpose: digital input acquisition timing engine with APB registers
// Assumes: all inputs synchronous to clk; APB master holds requests
// Notes:   sample memory doubles as waveform FIFO and pretrigger ring
// Functional notes
// R1: capture all lines on chosen sample edge
// R2: sample while FIFO full raises overflow
// R3: one sample holds every task line
// R4: sample strobe out active high by default
// R5: timebase divided into sample clock, never output
// R6: sample clock source and polarity selectable
// R7: without start trigger, software start begins
// R8: stop on count, reference, or software stop
// R9: delay from start to first sample
// R10: start source selectable, rising or falling
// R11: analog start source uses rising edge
// R12: start trigger output is active high pulse
// R13: posttrigger count is buffer minus pretrigger
// R14: reference trigger armed after pretrigger samples
// R15: full pretrigger buffer discards oldest sample
// R16: stop after exact posttrigger count
// R17: analog reference edge as configured
// R18: reference trigger output active high
// R19: level hold gates internal sample clock
// R20: one filter setting for all lines
// R21: filter width in 25 ns steps
// R22: level passes after consecutive filter samples
// R23: change event fires and samples lines
// R24: pretrigger above buffer refused, error flagged
`timescale 1ns/10ps
module acq_timing_engine
    import acq_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // apb slave
    input  wire logic [11:0]                paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // module lines and trigger sources
    input  wire logic [acq_pkg::LINES-1:0]  din,
    input  wire logic [7:0]                 trig_src,
    input  wire logic                       ext_timebase,
    // routed timing outputs
    output logic                            input_sample_strobe,
    output logic                            input_begin_trigger,
    output logic                            input_stop_ref_trigger,
    output logic                            edge_change_event
);
    import acq_pkg::*;

    // picks one source bit by code
    function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
        return v[s];
    endfunction

    // register file
    logic [31:0]      ctrl_q;                      // mode and routing
    logic [15:0]      div_q;                       // timebase divisor
    logic [15:0]      count_q;                     // finite count / buffer size
    logic [15:0]      pre_q;                       // pretrigger count
    logic [15:0]      delay_q;                     // start to first sample
    logic [7:0]       filt_q;                      // filter width in steps
    logic [LINES-1:0] rise_q;                      // change detect rising mask
    logic [LINES-1:0] fall_q;                      // change detect falling mask
    logic             ovf_q;                       // sticky overflow
    logic             cfg_q;                       // sticky configuration error
    logic [31:0]      prdata_q;                    // captured read data

    // bus decode
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire setup = psel & ~penable;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_stat = paddr == OFS_STAT;
    wire hit_data = paddr == OFS_DATA;
    wire hit_cmd = paddr == OFS_CMD;
    wire hit_any = hit_ctrl | hit_stat | hit_data | hit_cmd | (paddr == OFS_DIV) | (paddr == OFS_COUNT)
                 | (paddr == OFS_PRE) | (paddr == OFS_DELAY) | (paddr == OFS_FILT) | (paddr == OFS_LEVEL)
                 | (paddr == OFS_RISE) | (paddr == OFS_FALL);
    wire cmd_start = wr & hit_cmd & pwdata[C_START];
    wire cmd_stop = wr & hit_cmd & pwdata[C_STOP];
    assign pready = 1'b1;                          // never waits
    assign pslverr = acc & ~hit_any;
    assign prdata = prdata_q;

    // control fields
    wire       finite = ctrl_q[B_FINITE];
    wire       ref_en = ctrl_q[B_REF_EN];
    wire       trg_en = ctrl_q[B_TRG_EN];
    wire       filt_en = ctrl_q[B_FILT_EN];
    wire [2:0] st_src = ctrl_q[F_ST_SRC +: 3];
    wire [2:0] ref_src = ctrl_q[F_REF_SRC +: 3];
    wire [2:0] hold_src = ctrl_q[F_HOLD_SRC +: 3];
    wire [3:0] clk_src = ctrl_q[F_CLK_SRC +: 4];

    // engine state
    acq_state_type    st_q, st_d;
    logic [15:0]      div_cnt_q;                   // timebase divider
    logic [15:0]      dly_q;                       // delay counter
    logic [15:0]      tot_q;                       // samples taken
    logic [15:0]      post_q;                      // samples after reference
    logic             trigd_q;                     // reference accepted
    logic [AW-1:0]    wp_q, rp_q;                  // memory pointers
    logic [AW:0]      lvl_q;                       // stored samples
    logic [7:0]       src_q;                       // sources one cycle ago
    logic             tb_q;                        // timebase one cycle ago
    logic [LINES-1:0] line_q, smp_q, prev_q;       // filtered, filter sample, last filtered
    logic [15:0]      fcnt_q;                      // filter clock divider
    logic [LINES-1:0] mem_rdata;

    // filter clock: half the minimum width, so two agreeing samples span it
    wire [15:0] half_w = 16'((32'(filt_q) * STEP_CYC) >> 1);  // see R21
    wire        ftick = fcnt_q >= ((half_w == 16'h0) ? 16'h0 : half_w - 16'h1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fcnt_q <= 16'h0000;
        end else begin
            fcnt_q <= ftick ? 16'h0000 : fcnt_q + 16'h0001;
        end
    end

    // per-line debounce, one shared tick and width for the module
    generate
        for (genvar i = 0; i < LINES; i++) begin : g_filt
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    smp_q[i] <= 1'b0;
                    line_q[i] <= 1'b0;
                end else if (!filt_en) begin       // see R20
                    smp_q[i] <= din[i];
                    line_q[i] <= din[i];
                end else if (ftick) begin
                    smp_q[i] <= din[i];
                    if (din[i] == smp_q[i]) begin
                        line_q[i] <= din[i];       // see R22
                    end
                end
            end
        end
    endgenerate

    // change detection on filtered lines
    wire chg = |((line_q & ~prev_q & rise_q) | (~line_q & prev_q & fall_q));  // see R23

    // edge and level taps on the sources
    wire [7:0] src_rise = trig_src & ~src_q;
    wire [7:0] src_fall = ~trig_src & src_q;
    wire st_fall = ctrl_q[B_ST_FALL] & (st_src != SRC_ACMP);                   // see R11
    wire st_edge = st_fall ? pick(src_fall, st_src) : pick(src_rise, st_src);  // see R10
    wire ref_edge = ctrl_q[B_REF_FALL] ? pick(src_fall, ref_src)
                                       : pick(src_rise, ref_src);               // see R17
    wire hold_on = ctrl_q[B_HOLD_EN] & (pick(trig_src, hold_src) ^ ctrl_q[B_HOLD_LOW]);

    // sample clock generation
    wire tb_tick = ctrl_q[B_TB_EXT] ? (ext_timebase & ~tb_q) : 1'b1;           // see R5
    wire div_end = div_cnt_q >= ((div_q == 16'h0) ? 16'h0 : div_q - 16'h1);
    wire run = st_q == ST_RUN;
    wire int_stb = run & tb_tick & div_end & ~hold_on;                         // see R19
    wire ext_stb = ctrl_q[B_CLK_FALL] ? pick(src_fall, clk_src[2:0]) : pick(src_rise, clk_src[2:0]);
    wire smp_evt = (clk_src == CLK_SRC_TB) ? int_stb
                 : (clk_src == CLK_SRC_CHG) ? chg
                 : (clk_src[3] ? 1'b0 : ext_stb);                              // see R6
    wire sample = run & smp_evt & ~hold_on;                                    // see R1

    // fifo and ring bookkeeping
    wire [15:0] post_tgt = count_q - pre_q;                                    // see R13
    wire        armed = tot_q >= pre_q;
    wire        full = lvl_q == DEPTH;
    wire        ring = ref_en & ~trigd_q & ({7'h00, lvl_q} >= pre_q);  // ring holds only the pretrigger samples
    wire        push_ok = sample & (ring | ~full);
    wire        discard = push_ok & ring;                                      // see R15
    wire        pop = acc & ~pwrite & hit_data & (lvl_q != '0) & ~discard;
    wire        adv_rd = discard | pop;
    wire        bad_cfg = ref_en & ((pre_q > count_q) | (count_q > 16'(DEPTH)));
    wire        take_ref = run & ref_en & armed & ~trigd_q & ref_edge;         // see R14
    wire        post_end = trigd_q & push_ok & (post_q + 16'h1 == post_tgt);
    wire        fin_end = finite & ~ref_en & push_ok & (tot_q + 16'h1 == count_q);

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE, ST_DONE: begin
                if (cmd_start && !bad_cfg) begin                               // see R24
                    st_d = trg_en ? ST_WAIT : (delay_q != 16'h0) ? ST_DELAY : ST_RUN;  // see R7
                end
            end
            ST_WAIT: begin
                if (cmd_stop) begin
                    st_d = ST_DONE;
                end else if (st_edge) begin
                    st_d = (delay_q != 16'h0) ? ST_DELAY : ST_RUN;
                end
            end
            ST_DELAY: begin
                if (cmd_stop) begin
                    st_d = ST_DONE;
                end else if (dly_q <= 16'h1) begin
                    st_d = ST_RUN;                 // see R9
                end
            end
            ST_RUN: begin
                if (cmd_stop || post_end || fin_end) begin
                    st_d = ST_DONE;                // see R8
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // state, counters and pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            dly_q <= 16'h0000;
            div_cnt_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            dly_q <= (st_q != ST_DELAY) ? delay_q : dly_q - 16'h0001;
            if (!run) begin
                div_cnt_q <= 16'h0000;             // first sample a full period after start
            end else if (tb_tick && !hold_on) begin
                div_cnt_q <= div_end ? 16'h0000 : div_cnt_q + 16'h0001;
            end
        end
    end

    wire restart = (st_q == ST_IDLE || st_q == ST_DONE) && st_d != st_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tot_q <= 16'h0000;
            post_q <= 16'h0000;
            trigd_q <= 1'b0;
        end else if (restart) begin
            tot_q <= 16'h0000;
            post_q <= 16'h0000;
            trigd_q <= 1'b0;
        end else begin
            if (push_ok) begin
                tot_q <= tot_q + 16'h0001;
                post_q <= trigd_q ? post_q + 16'h0001 : post_q;  // see R16
            end
            if (take_ref) begin
                trigd_q <= 1'b1;
            end
        end
    end

    // memory pointers; a restart empties the buffer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            lvl_q <= '0;
        end else if (restart) begin
            wp_q <= '0;
            rp_q <= '0;
            lvl_q <= '0;
        end else begin
            wp_q <= push_ok ? wp_q + 1'b1 : wp_q;
            rp_q <= adv_rd ? rp_q + 1'b1 : rp_q;
            lvl_q <= lvl_q + {8'h00, push_ok & ~ring} - {8'h00, pop};
        end
    end

    sample_ram #(.W(LINES), .AW(AW)) u_ram (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (push_ok),
        .waddr (wp_q),
        .wdata (line_q),                           // see R3
        .raddr (rp_q),
        .rdata (mem_rdata)
    );

    // source history and routed outputs, all registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_q <= 8'h00;
            tb_q <= 1'b0;
            prev_q <= '0;
            input_sample_strobe <= 1'b0;
            input_begin_trigger <= 1'b0;
            input_stop_ref_trigger <= 1'b0;
            edge_change_event <= 1'b0;
        end else begin
            src_q <= trig_src;
            tb_q <= ext_timebase;
            prev_q <= line_q;
            input_sample_strobe <= sample ^ ctrl_q[B_STB_INV];     // see R4
            input_begin_trigger <= (st_q == ST_WAIT) & st_edge;    // see R12
            input_stop_ref_trigger <= take_ref;                    // see R18
            edge_change_event <= chg;
        end
    end

    // software registers; status set wins over a write-one clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            div_q <= DIV_RST;
            count_q <= COUNT_RST;
            pre_q <= 16'h0000;
            delay_q <= 16'h0000;
            filt_q <= FILT_RST;
            rise_q <= '0;
            fall_q <= '0;
            ovf_q <= 1'b0;
            cfg_q <= 1'b0;
        end else begin
            if (wr && hit_ctrl) ctrl_q <= pwdata;
            if (wr && paddr == OFS_DIV) div_q <= pwdata[15:0];
            if (wr && paddr == OFS_COUNT) count_q <= pwdata[15:0];
            if (wr && paddr == OFS_PRE) pre_q <= pwdata[15:0];
            if (wr && paddr == OFS_DELAY) delay_q <= pwdata[15:0];
            if (wr && paddr == OFS_FILT) filt_q <= pwdata[7:0];
            if (wr && paddr == OFS_RISE) rise_q <= pwdata[LINES-1:0];
            if (wr && paddr == OFS_FALL) fall_q <= pwdata[LINES-1:0];
            ovf_q <= (sample & full & ~ring) | (ovf_q & ~(wr & hit_stat & pwdata[S_OVF]));  // see R2
            cfg_q <= (cmd_start & bad_cfg & (st_q == ST_IDLE || st_q == ST_DONE))
                   | (cfg_q & ~(wr & hit_stat & pwdata[S_CFG]));
        end
    end

    // read data captured in the setup cycle
    wire [31:0] stat_w = {26'h0, cfg_q, ovf_q, st_q == ST_DONE, trigd_q, armed, run};
    wire [31:0] rd_w = hit_ctrl ? ctrl_q
                     : (paddr == OFS_DIV) ? {16'h0, div_q}
                     : (paddr == OFS_COUNT) ? {16'h0, count_q}
                     : (paddr == OFS_PRE) ? {16'h0, pre_q}
                     : (paddr == OFS_DELAY) ? {16'h0, delay_q}
                     : (paddr == OFS_FILT) ? {24'h0, filt_q}
                     : hit_stat ? stat_w
                     : hit_data ? {24'h0, mem_rdata}
                     : (paddr == OFS_LEVEL) ? {23'h0, lvl_q}
                     : (paddr == OFS_RISE) ? {24'h0, rise_q}
                     : (paddr == OFS_FALL) ? {24'h0, fall_q}
                     : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_w;
        end
    end

    // checks
    AST_OVF: assert property (@(posedge clk) disable iff (!rst_b)  // see R2
        sample && full && !ring |=> ovf_q && $stable(wp_q)) else $error("overflow not flagged");
    AST_CFG: assert property (@(posedge clk) disable iff (!rst_b)  // see R24
        cmd_start && bad_cfg && st_q == ST_IDLE |=> cfg_q && st_q == ST_IDLE) else $error("bad start taken");
    AST_SWSTART: assert property (@(posedge clk) disable iff (!rst_b)  // see R7
        st_q == ST_IDLE && cmd_start && !bad_cfg && !trg_en && delay_q == 16'h0 |=> run)
        else $error("software start ignored");
    AST_BEGIN: assert property (@(posedge clk) disable iff (!rst_b)  // see R12
        st_q == ST_WAIT && st_edge && !cmd_stop |=> input_begin_trigger && st_q != ST_WAIT)
        else $error("start pulse missing");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)  // see R19
        hold_on |-> !sample ##1 input_sample_strobe == $past(ctrl_q[B_STB_INV])) else $error("sample during hold");
    AST_ARM: assert property (@(posedge clk) disable iff (!rst_b)  // see R14
        run && !trigd_q && tot_q < pre_q |=> !trigd_q) else $error("reference taken before pretrigger");
    AST_RING: assert property (@(posedge clk) disable iff (!rst_b)  // see R15
        discard |=> lvl_q == $past(lvl_q) && rp_q == $past(rp_q) + 1'b1) else $error("ring did not discard");
    AST_POST: assert property (@(posedge clk) disable iff (!rst_b)  // see R16
        run && post_end && !restart |=> st_q == ST_DONE ##1 st_q != ST_RUN) else $error("post count overrun");
    AST_FILT: assert property (@(posedge clk) disable iff (!rst_b)  // see R22
        filt_en && !ftick && $stable(ctrl_q) |=> $stable(line_q)) else $error("filter moved off tick");
endmodule

//--- verification/line_source.sv
// Purpose: model of the plug-in parallel input modules and trigger terminals
// Assumes: lines and trigger sources change just after a rising clk edge
// Notes:   external timebase runs free; its phase is unrelated to any frame
`timescale 1ns/10ps
module line_source (
    // clock
    input  wire logic       clk,
    // levels asked for by the bench
    input  wire logic [7:0] lines_set,
    input  wire logic [7:0] trig_set,
    // module side outputs
    output logic      [7:0] din          = 8'h00,
    output logic      [7:0] trig_src     = 8'h00,
    output logic            ext_timebase = 1'b0
);
    // registered drivers, so the engine never sees a change at its sampling edge
    always @(posedge clk) begin
        din      <= lines_set;
        trig_src <= trig_set;
    end
    // free running timebase, toggled every third clk by a registered driver
    // so it never moves at the engine's sampling edge
    logic [1:0] tb_div = 2'h0;                      // toggle divider
    always @(posedge clk) begin
        tb_div <= (tb_div == 2'h2) ? 2'h0 : tb_div + 2'h1;
        if (tb_div == 2'h2) ext_timebase <= ~ext_timebase;
    end
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench of the acquisition timing engine
// Assumes: APB slave answers whenever it likes; bench waits for pready
// Notes:   lines held steady during a capture, so each sample must equal them
`timescale 1ns/10ps
module testbench;
    import acq_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    integer      seed = 32'had09e5c2;
    logic        pready, pslverr, stb, beg, refo, chg, tb;
    logic [7:0]  din, trig_src, lines_set = 8'h00, trig_set = 8'h00;
    int          n_fail = 0, n_compared = 0, cycles = 0, strobes = 0, post = 0, begins = 0, changes = 0, c;
    logic        seen_ref = 1'b0;
    // 5 ns period
    always #2.5 clk = ~clk;
    line_source partner (.clk(clk), .lines_set(lines_set), .trig_set(trig_set), .din(din),
                         .trig_src(trig_src), .ext_timebase(tb));
    acq_timing_engine uut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din(din), .trig_src(trig_src), .ext_timebase(tb), .input_sample_strobe(stb),
        .input_begin_trigger(beg), .input_stop_ref_trigger(refo), .edge_change_event(chg));
    // pulse counters and a hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (stb === 1'b1) strobes <= strobes + 1;
        if (stb === 1'b1 && seen_ref) post <= post + 1;
        if (refo === 1'b1) seen_ref <= 1'b1;
        if (beg === 1'b1) begins <= begins + 1;
        if (chg === 1'b1) changes <= changes + 1;
        if (cycles == 30000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // one APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // poll status until done, bounded
    task automatic wait_done();
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, OFS_STAT, 32'h0);
            if (rd[S_DONE] === 1'b1) return;
        end
        n_fail++;                                            // never finished counts as a mismatch
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, OFS_DIV, 32'h0);   check(rd, 32'h4);
        apb(1'b0, OFS_COUNT, 32'h0); check(rd, 32'h100);
        apb(1'b0, OFS_FILT, 32'h0);  check(rd, 32'h1);
        apb(1'b0, 12'h0F0, 32'h0);   check({31'h0, rerr}, 32'h1);
        // finite captures of random lines at several divisors
        for (int k = 0; k < 4; k++) begin
            lines_set <= 8'($random(seed));
            c = 1 + ($random(seed) & 32'h7);
            apb(1'b1, OFS_DIV, 32'(1 + k * 2));
            apb(1'b1, OFS_COUNT, 32'(c));
            apb(1'b1, OFS_CTRL, 32'h0800_0001 | (32'(k == 3) << B_TB_EXT));
            strobes = 0;
            apb(1'b1, OFS_CMD, 32'h1);
            wait_done();
            check(32'(strobes), 32'(c));
            apb(1'b0, OFS_LEVEL, 32'h0); check(rd, 32'(c));
            apb(1'b0, OFS_DATA, 32'h0);  check(rd, {24'h0, lines_set});
        end
        // continuous at full rate overruns the 256-word memory
        apb(1'b1, OFS_DIV, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0800_0000);
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (600) @(posedge clk);
        apb(1'b1, OFS_CMD, 32'h2);
        apb(1'b0, OFS_STAT, 32'h0);  check({31'h0, rd[S_OVF]}, 32'h1);
        apb(1'b0, OFS_LEVEL, 32'h0); check(rd, 32'(DEPTH));
        // pretrigger above buffer size is refused
        apb(1'b1, OFS_STAT, 32'h30);
        apb(1'b1, OFS_COUNT, 32'h4);
        apb(1'b1, OFS_PRE, 32'h5);
        apb(1'b1, OFS_CTRL, 32'h0801_0003);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b0, OFS_STAT, 32'h0);  check(rd & 32'h21, 32'h20);
        // early reference ignored, later one ends after COUNT-PRE samples
        apb(1'b1, OFS_DIV, 32'h10);
        apb(1'b1, OFS_COUNT, 32'h8);
        apb(1'b1, OFS_PRE, 32'h3);
        apb(1'b1, OFS_CMD, 32'h1);
        trig_set <= 8'h02;                                   // edge while running, before the third sample
        repeat (30) @(posedge clk);
        trig_set <= 8'h00;
        check({31'h0, seen_ref}, 32'h0);
        repeat (60) @(posedge clk);
        trig_set <= 8'h02;
        wait_done();
        check(32'(post), 32'h5);
        apb(1'b0, OFS_LEVEL, 32'h0); check(rd, 32'h8);
        // start trigger on terminal 2, both edge senses
        for (int f = 0; f < 2; f++) begin
            trig_set <= 8'(f << 2);
            apb(1'b1, OFS_CTRL, 32'h0800_2004 | 32'(f << B_ST_FALL));
            begins = 0;
            apb(1'b1, OFS_CMD, 32'h1);
            repeat (10) @(posedge clk);
            trig_set <= 8'((1 - f) << 2);
            repeat (10) @(posedge clk);
            check(32'(begins), 32'h1);
            apb(1'b1, OFS_CMD, 32'h2);
        end
        // level hold on terminal 3 masks the divided clock, release resumes it
        trig_set <= 8'h08;
        apb(1'b1, OFS_CTRL, 32'h0830_0040);
        strobes = 0;
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (40) @(posedge clk);
        check(32'(strobes), 32'h0);
        trig_set <= 8'h00;
        repeat (40) @(posedge clk);
        apb(1'b1, OFS_CMD, 32'h2);
        check({31'h0, strobes > 0}, 32'h1);
        // lines 0 and 7 rise, but only line 0's filtered rise is in the rise mask and fires the change event, which takes one sample
        lines_set <= 8'h00;
        apb(1'b1, OFS_RISE, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0900_0200);
        apb(1'b1, OFS_CMD, 32'h1);
        changes = 0;
        lines_set <= 8'h81;
        repeat (20) @(posedge clk);
        check(32'(changes), 32'h1);
        apb(1'b0, OFS_LEVEL, 32'h0); check(rd, 32'h1);
        apb(1'b0, OFS_DATA, 32'h0);  check(rd, 32'h81);
        complete_run();
    end
endmodule
